// ==== hw/tmrlr_top.sv ====
// file: axi4-lite register block for timer interrupt clear and interval load registers
`timescale 1ns/100ps
module tmrlr_top
  import tmrlr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [6:0]  evt_in,
  output tmrlr_load_t      load_out,
  output logic             mode_32bit,
  output logic             irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // pack 7 event bits into the 32-bit register layout
  function automatic logic [31:0] tmrlr_spread(input logic [6:0] v);
    tmrlr_spread = 32'h0000_0000;
    tmrlr_spread[TMRLR_BIT_A_TIMEOUT] = v[0];
    tmrlr_spread[TMRLR_BIT_A_MATCH]   = v[1];
    tmrlr_spread[TMRLR_BIT_A_EVENT]   = v[2];
    tmrlr_spread[TMRLR_BIT_RTC]       = v[3];
    tmrlr_spread[TMRLR_BIT_B_TIMEOUT] = v[4];
    tmrlr_spread[TMRLR_BIT_B_MATCH]   = v[5];
    tmrlr_spread[TMRLR_BIT_B_EVENT]   = v[6];
  endfunction

  // gather the 7 event bits out of a register word
  function automatic logic [6:0] tmrlr_gather(input logic [31:0] w);
    tmrlr_gather = {w[TMRLR_BIT_B_EVENT], w[TMRLR_BIT_B_MATCH], w[TMRLR_BIT_B_TIMEOUT],
                    w[TMRLR_BIT_RTC], w[TMRLR_BIT_A_EVENT], w[TMRLR_BIT_A_MATCH],
                    w[TMRLR_BIT_A_TIMEOUT]};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  waddr_ff;
  logic        aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        w_held_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [2:0]  cfg_ff;
  logic [6:0]  mask_ff;
  logic [15:0] a_load_ff;
  logic [15:0] b_load_ff;
  logic        a_wr_ff;
  logic        b_wr_ff;
  logic [6:0]  raw_flags;

  // ---------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_held_ff & w_held_ff & ~bvalid_ff;

  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // hold the address and data until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      waddr_ff   <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        waddr_ff   <= s_axi_awaddr;
      end else if (wr_go) aw_held_ff <= 1'b0;
      if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (wr_go) w_held_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  wire [7:0] wreg     = {waddr_ff[7:2], 2'b00};
  wire       wr_cfg   = wr_go & (wreg == TMRLR_OFF_CFG);
  wire       wr_mask  = wr_go & (wreg == TMRLR_OFF_MASK);
  wire       wr_iclr  = wr_go & (wreg == TMRLR_OFF_ICLR);
  wire       wr_aload = wr_go & (wreg == TMRLR_OFF_ALOAD);
  wire       wr_bload = wr_go & (wreg == TMRLR_OFF_BLOAD);
  wire       wr_ro    = wr_go & ((wreg == TMRLR_OFF_RAW) | (wreg == TMRLR_OFF_MIS));
  wire       wr_hit   = wr_cfg | wr_mask | wr_iclr | wr_aload | wr_bload | wr_ro;
  wire       is_32    = (cfg_ff == TMRLR_CFG_32BIT);
  wire       lo_en    = wstrb_ff[0] | wstrb_ff[1];
  wire       hi_en    = wstrb_ff[2] | wstrb_ff[3];

  // merge byte lanes into a 16-bit half
  function automatic logic [15:0] tmrlr_merge(input logic [15:0] old, input logic [15:0] nw,
                                              input logic [1:0] be);
    tmrlr_merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // clear pulses only on bits written as one; zero bits leave flags alone
  wire [6:0] clr_vec = wr_iclr ? (tmrlr_gather(wdata_ff) & {7{wstrb_ff[0] | wstrb_ff[1]}})
                               : 7'h00;

  // a low half always takes the write; the upper half maps onto b only in 32-bit mode
  wire a_lo_wr = wr_aload & lo_en;
  wire b_via_a = wr_aload & hi_en & is_32;
  wire b_direct = wr_bload & lo_en & ~is_32;

  wire [15:0] nxt_a_load = a_lo_wr ? tmrlr_merge(a_load_ff, wdata_ff[15:0], wstrb_ff[1:0])
                                   : a_load_ff;
  wire [15:0] nxt_b_load = b_via_a ? tmrlr_merge(b_load_ff, wdata_ff[31:16], wstrb_ff[3:2]) :
                           b_direct ? tmrlr_merge(b_load_ff, wdata_ff[15:0], wstrb_ff[1:0]) :
                           b_load_ff;

  // control registers and load values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff    <= TMRLR_CFG_RST;
      mask_ff   <= 7'h00;
      a_load_ff <= TMRLR_LOAD_RST;
      b_load_ff <= TMRLR_LOAD_RST;
      a_wr_ff   <= 1'b0;
      b_wr_ff   <= 1'b0;
    end else begin
      if (wr_cfg && wstrb_ff[0]) cfg_ff <= wdata_ff[2:0];
      if (wr_mask && lo_en) mask_ff <= tmrlr_gather(wdata_ff);
      a_load_ff <= nxt_a_load;
      b_load_ff <= nxt_b_load;
      a_wr_ff   <= a_lo_wr;
      b_wr_ff   <= b_via_a | b_direct;
    end
  end

  // write response: slverr for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= TMRLR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? TMRLR_RESP_OKAY : TMRLR_RESP_SLVERR;
    end else if (s_axi_bready) bvalid_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------
  tmrlr_evt_bank #(
    .NUM (TMRLR_NUM_EVT)
  ) u_evt (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .evt_pulse (evt_in),
    .clr_pulse (clr_vec),
    .raw_ff    (raw_flags)
  );

  wire [6:0] masked = raw_flags & mask_ff;
  assign irq = |masked;

  // ---------------------------------------------------------------
  // read channel; upper half of a reads b only in 32-bit mode
  // ---------------------------------------------------------------
  wire [7:0]  rreg   = {s_axi_araddr[7:2], 2'b00};
  wire [15:0] a_high = is_32 ? b_load_ff : TMRLR_HALF_ZERO;
  wire        ar_take = s_axi_arvalid & s_axi_arready;

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  logic [31:0] rd_word;
  logic        rd_hit;
  // read mux; reserved bits come back as zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (rreg)
      TMRLR_OFF_CFG:   rd_word = {29'h0000_0000, cfg_ff};
      TMRLR_OFF_MASK:  rd_word = tmrlr_spread(mask_ff);
      TMRLR_OFF_RAW:   rd_word = tmrlr_spread(raw_flags);
      TMRLR_OFF_MIS:   rd_word = tmrlr_spread(masked);
      TMRLR_OFF_ICLR:  rd_word = 32'h0000_0000;
      TMRLR_OFF_ALOAD: rd_word = {a_high, a_load_ff};
      TMRLR_OFF_BLOAD: rd_word = {TMRLR_HALF_ZERO, b_load_ff};
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= TMRLR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_hit ? TMRLR_RESP_OKAY : TMRLR_RESP_SLVERR;
    end else if (s_axi_rready) rvalid_ff <= 1'b0;
  end

  assign load_out   = '{a_load: a_load_ff, b_load: b_load_ff, a_wr: a_wr_ff, b_wr: b_wr_ff};
  assign mode_32bit = is_32;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_clear_drops_raw: assert property (@(posedge aclk) disable iff (!aresetn)
    (clr_vec[0] && !evt_in[0]) |=> !raw_flags[0])
    else $error("cleared timeout flag still set");
  a_zero_keeps_raw: assert property (@(posedge aclk) disable iff (!aresetn)
    (raw_flags[4] && !clr_vec[4]) |=> raw_flags[4])
    else $error("flag lost without clear");
  a_clear_bit_map: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_iclr && lo_en && wdata_ff[10] |-> clr_vec[6])
    else $error("bit 10 does not clear b event");
  a_raw_sets_always: assert property (@(posedge aclk) disable iff (!aresetn)
    evt_in[3] |=> raw_flags[3])
    else $error("event did not set raw flag");
  a_masked_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> |(raw_flags & mask_ff))
    else $error("irq without enabled flag");
  a_b_locked_32: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_bload && is_32 && !b_via_a) |=> $stable(b_load_ff))
    else $error("b load changed in 32-bit mode");
  a_high_zero_16: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rreg == TMRLR_OFF_ALOAD && !is_32) |=> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half not zero in 16-bit mode");
  a_a_load_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_aload && wstrb_ff[1:0] == 2'b11) |=> a_load_ff == $past(wdata_ff[15:0]))
    else $error("a low half not loaded");
  a_b_via_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_aload && is_32 && wstrb_ff[3:2] == 2'b11) |=> b_load_ff == $past(wdata_ff[31:16]))
    else $error("upper half did not reach b");
  a_b_direct_16: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_bload && !is_32 && wstrb_ff[1:0] == 2'b11) |=> b_load_ff == $past(wdata_ff[15:0]))
    else $error("b field not loaded in 16-bit mode");

  // engine pulses and read views; these catch a wrong mux leg that the write checks miss
  a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (evt_in[2] && clr_vec[2]) |=> raw_flags[2])
    else $error("event lost to a clear in the same cycle");
  a_a_pulse_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    a_lo_wr |=> load_out.a_wr)
    else $error("a load write gave no pulse");
  a_b_quiet_32: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_bload && is_32) |=> !load_out.b_wr)
    else $error("b load pulsed on an ignored write");
  a_high_tracks_b: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rreg == TMRLR_OFF_ALOAD && is_32) |=> s_axi_rdata[31:16] == $past(b_load_ff))
    else $error("upper half does not show b in 32-bit mode");
  a_b_16_ignores_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_aload && !is_32) |=> $stable(b_load_ff))
    else $error("upper half write reached b in 16-bit mode");
  a_mask_view: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rreg == TMRLR_OFF_MIS) |=>
      (s_axi_rdata & ~tmrlr_spread($past(mask_ff))) == 32'h0000_0000)
    else $error("masked status shows a disabled bit");
  a_status_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rreg == TMRLR_OFF_RAW) |=> (s_axi_rdata & ~TMRLR_IRQ_BITS) == 32'h0000_0000)
    else $error("raw status shows a bit outside the map");

endmodule

// ==== include/tmrlr_pkg.sv ====
// package: register map, field positions, reset values and carrier types of the timer load block
package tmrlr_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TMRLR_OFF_CFG    = 8'h00;  // timer_configuration
  localparam logic [7:0] TMRLR_OFF_MASK   = 8'h18;  // interrupt_mask
  localparam logic [7:0] TMRLR_OFF_RAW    = 8'h1c;  // raw_interrupt_status
  localparam logic [7:0] TMRLR_OFF_MIS    = 8'h20;  // masked_interrupt_status
  localparam logic [7:0] TMRLR_OFF_ICLR   = 8'h24;  // interrupt_clear
  localparam logic [7:0] TMRLR_OFF_ALOAD  = 8'h28;  // timer_a_interval_load
  localparam logic [7:0] TMRLR_OFF_BLOAD  = 8'h2c;  // timer_b_interval_load

  // ---------------------------------------------------------------
  // interrupt bit positions
  // ---------------------------------------------------------------
  localparam int TMRLR_BIT_A_TIMEOUT   = 0;
  localparam int TMRLR_BIT_A_MATCH     = 1;
  localparam int TMRLR_BIT_A_EVENT     = 2;
  localparam int TMRLR_BIT_RTC         = 3;
  localparam int TMRLR_BIT_B_TIMEOUT   = 8;
  localparam int TMRLR_BIT_B_MATCH     = 9;
  localparam int TMRLR_BIT_B_EVENT     = 10;
  localparam int TMRLR_NUM_EVT         = 7;

  // implemented bits of the interrupt registers
  localparam logic [31:0] TMRLR_IRQ_BITS = 32'h0000_070f;

  // ---------------------------------------------------------------
  // reset values and configuration codes
  // ---------------------------------------------------------------
  localparam logic [15:0] TMRLR_LOAD_RST   = 16'hffff;
  localparam logic [15:0] TMRLR_HALF_ZERO  = 16'h0000;
  localparam logic [2:0]  TMRLR_CFG_32BIT  = 3'h0;   // code that selects combined operation
  localparam logic [2:0]  TMRLR_CFG_RST    = 3'h0;

  // axi response codes
  localparam logic [1:0] TMRLR_RESP_OKAY   = 2'b00;
  localparam logic [1:0] TMRLR_RESP_SLVERR = 2'b10;

  // load values handed to the counting engines
  typedef struct packed {
    logic [15:0] a_load;
    logic [15:0] b_load;
    logic        a_wr;
    logic        b_wr;
  } tmrlr_load_t;

endpackage

// ==== hw/tmrlr_evt_bank.sv ====
// file: sticky raw interrupt flags, one per timer event, with write-one clear
`timescale 1ns/100ps
module tmrlr_evt_bank
  import tmrlr_pkg::*;
#(
  parameter int NUM = TMRLR_NUM_EVT
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [NUM-1:0] evt_pulse,
  input  wire logic [NUM-1:0] clr_pulse,
  output logic      [NUM-1:0] raw_ff
);

  // refuse an empty bank while elaborating rather than at run time
  if (NUM < 1) begin : g_bad_num
    $error("tmrlr_evt_bank needs at least one event");
  end

  // ---------------------------------------------------------------
  // one flag per event; a set in the clear cycle wins so no event is lost
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM; gi++) begin : g_flag
      logic nxt_raw;
      assign nxt_raw = evt_pulse[gi] | (raw_ff[gi] & ~clr_pulse[gi]);
      always_ff @(posedge aclk) begin
        if (!aresetn) raw_ff[gi] <= 1'b0;
        else raw_ff[gi] <= nxt_raw;
      end
    end
  endgenerate

endmodule

// ==== bench/tmrlr_top_test.sv ====
// testbench: drives the timer load and interrupt clear block over axi4-lite and checks answers
`timescale 1ns/100ps
module tmrlr_top_test;
  import tmrlr_pkg::*;

  // ---------------------------------------------------------------
  // signals and instance
  // ---------------------------------------------------------------
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [6:0]  evt_in;
  tmrlr_load_t load_out;
  logic        mode_32bit, irq;
  int          errors, compares;
  int          a_pulses, b_pulses;

  tmrlr_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .evt_in(evt_in), .load_out(load_out), .mode_32bit(mode_32bit), .irq(irq)
  );

  // clock: 40 ns period
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // count one-cycle load pulses; sampling on the falling edge sees each pulse once
  always @(negedge aclk) begin
    if (load_out.a_wr === 1'b1) a_pulses++;
    if (load_out.b_wr === 1'b1) b_pulses++;
  end

  // ---------------------------------------------------------------
  // compare tasks and closing
  // ---------------------------------------------------------------
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // bus tasks: handshakes are judged on the falling edge, since inputs only move on rising
  // edges the values seen there are the ones the next rising edge samples
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    b_hs = 0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid && bready;
      r     = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_hs, r_hs;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    r_hs = 0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid && rready;
      d     = rdata;
      r     = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // read a register and compare word and response
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk32(what, exp, d);
    chk32({what, " resp"}, {30'h0, TMRLR_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk32("bresp", {30'h0, TMRLR_RESP_OKAY}, {30'h0, r});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset;
    chk1("mode after reset", 1'b1, mode_32bit);
    chk1("irq after reset", 1'b0, irq);
    chk32("a_load reset", 32'h0000_ffff, {16'h0000, load_out.a_load});
    rd_chk("a load reset", TMRLR_OFF_ALOAD, 32'hffff_ffff);
    rd_chk("b load reset", TMRLR_OFF_BLOAD, 32'h0000_ffff);
    $display("test reset done");
  endtask

  task automatic test_mode32;
    wr_ok(TMRLR_OFF_ALOAD, 32'h1234_5678);
    chk32("a_load", 32'h0000_5678, {16'h0000, load_out.a_load});
    chk32("b_load via a", 32'h0000_1234, {16'h0000, load_out.b_load});
    rd_chk("a load 32", TMRLR_OFF_ALOAD, 32'h1234_5678);
    wr_ok(TMRLR_OFF_BLOAD, 32'h0000_9abc);
    chk32("b_load kept", 32'h0000_1234, {16'h0000, load_out.b_load});
    rd_chk("b load 32", TMRLR_OFF_BLOAD, 32'h0000_1234);
    chk32("a pulses 32", 32'h0000_0001, a_pulses);
    chk32("b pulses 32", 32'h0000_0001, b_pulses);
    $display("test mode32 done");
  endtask

  task automatic test_mode16;
    wr_ok(TMRLR_OFF_CFG, 32'h0000_0004);
    chk1("mode 16", 1'b0, mode_32bit);
    rd_chk("a load upper zero", TMRLR_OFF_ALOAD, 32'h0000_5678);
    wr_ok(TMRLR_OFF_ALOAD, 32'haaaa_bbbb);
    chk32("a_load 16", 32'h0000_bbbb, {16'h0000, load_out.a_load});
    chk32("b_load untouched", 32'h0000_1234, {16'h0000, load_out.b_load});
    wr_ok(TMRLR_OFF_BLOAD, 32'h0000_4321);
    chk32("b_load 16", 32'h0000_4321, {16'h0000, load_out.b_load});
    rd_chk("b load 16", TMRLR_OFF_BLOAD, 32'h0000_4321);
    rd_chk("a load 16", TMRLR_OFF_ALOAD, 32'h0000_bbbb);
    wr_ok(TMRLR_OFF_CFG, 32'h0000_0000);
    rd_chk("a load back 32", TMRLR_OFF_ALOAD, 32'h4321_bbbb);
    chk32("a pulses 16", 32'h0000_0002, a_pulses);
    chk32("b pulses 16", 32'h0000_0002, b_pulses);
    $display("test mode16 done");
  endtask

  // each event: raw sets while masked off, masked view follows mask, zero clear keeps it
  task automatic test_irq;
    int pos [7];
    logic [31:0] bitv;
    pos = '{TMRLR_BIT_A_TIMEOUT, TMRLR_BIT_A_MATCH, TMRLR_BIT_A_EVENT, TMRLR_BIT_RTC,
            TMRLR_BIT_B_TIMEOUT, TMRLR_BIT_B_MATCH, TMRLR_BIT_B_EVENT};
    for (int i = 0; i < 7; i++) begin
      bitv = 32'h0000_0001 << pos[i];
      @(posedge aclk) evt_in <= 7'h01 << i;
      @(posedge aclk) evt_in <= 7'h00;
      rd_chk("raw unmasked", TMRLR_OFF_RAW, bitv);
      rd_chk("masked off", TMRLR_OFF_MIS, 32'h0000_0000);
      chk1("irq masked", 1'b0, irq);
      wr_ok(TMRLR_OFF_MASK, bitv);
      rd_chk("masked on", TMRLR_OFF_MIS, bitv);
      chk1("irq on", 1'b1, irq);
      wr_ok(TMRLR_OFF_ICLR, ~bitv & TMRLR_IRQ_BITS);
      rd_chk("zero clear keeps", TMRLR_OFF_RAW, bitv);
      wr_ok(TMRLR_OFF_ICLR, bitv);
      rd_chk("raw cleared", TMRLR_OFF_RAW, 32'h0000_0000);
      rd_chk("masked cleared", TMRLR_OFF_MIS, 32'h0000_0000);
      chk1("irq cleared", 1'b0, irq);
      wr_ok(TMRLR_OFF_MASK, 32'h0000_0000);
    end
    $display("test irq done");
  endtask

  task automatic test_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h40, 32'h5555_5555, r);
    chk32("unmapped bresp", {30'h0, TMRLR_RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h40, d, r);
    chk32("unmapped rresp", {30'h0, TMRLR_RESP_SLVERR}, {30'h0, r});
    chk32("unmapped rdata", 32'h0000_0000, d);
    $display("test unmapped done");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    errors = 0; compares = 0;
    a_pulses = 0; b_pulses = 0;
    aresetn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0000_0000; wstrb = 4'h0;
    wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    evt_in = 7'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    test_reset;
    test_mode32;
    test_mode16;
    test_irq;
    test_unmapped;
    tally_and_finish;
  end

  // the run needs roughly 300 cycles; twenty thousand marks a hang
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish;
  end
endmodule
